// file: include/eac_pkg.sv
/*
  eac_pkg: constants and types shared by the data-EEPROM access control block.
  Assumes a 250 MHz pclk and a 32-bit APB register bus, one register per aligned word.
*/
package eac_pkg;

  // clock period in ns, used to turn programming times into cycle counts
  localparam int unsigned CLK_PERIOD_NS = 4;

  // register indices; the byte address is four times the index
  localparam logic [7:0] CTRL_IDX       = 8'h1c;
  localparam logic [7:0] DATA_IDX       = 8'h1d;
  localparam logic [7:0] ADDR_IDX       = 8'h1e;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'h20;
  localparam logic [7:0] IRQ_MASK_IDX   = 8'h21;

  // control register field positions
  localparam int unsigned CTRL_READ_BIT  = 0;
  localparam int unsigned CTRL_PROG_BIT  = 1;
  localparam int unsigned CTRL_ARM_BIT   = 2;
  localparam int unsigned CTRL_RIE_BIT   = 3;
  localparam int unsigned CTRL_MODE_LSB  = 4;
  localparam int unsigned CTRL_MODE_MSB  = 5;

  // interrupt status bit positions
  localparam int unsigned EV_PROG_DONE = 0;
  localparam int unsigned EV_READ_DONE = 1;
  localparam int unsigned EV_REFUSED   = 2;
  localparam int unsigned EV_W         = 3;

  // programming modes
  localparam logic [1:0] MODE_ATOMIC     = 2'h0;
  localparam logic [1:0] MODE_ERASE_ONLY = 2'h1;
  localparam logic [1:0] MODE_WRITE_ONLY = 2'h2;
  localparam logic [1:0] MODE_RESERVED   = 2'h3;

  // values after reset, and the value of an erased byte
  localparam logic [1:0] MODE_RESET      = 2'h0;
  localparam logic [7:0] ADDR_RESET      = 8'h00;
  localparam logic [7:0] DATA_RESET      = 8'h00;
  localparam logic [7:0] ERASED_BYTE     = 8'hff;
  localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;

  // programming times in ns and their cycle counts (rounded up)
  localparam int unsigned PROG_ATOMIC_NS     = 3400000;
  localparam int unsigned PROG_SPLIT_NS      = 1800000;
  localparam int unsigned PROG_ATOMIC_CYCLES = (PROG_ATOMIC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PROG_SPLIT_CYCLES  = (PROG_SPLIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // short cycle counts
  localparam logic [2:0] ARM_WINDOW_CYCLES  = 3'h4;
  localparam logic [2:0] PROG_STALL_CYCLES  = 3'h2;
  localparam logic [2:0] READ_STALL_CYCLES  = 3'h4;

  localparam int unsigned TIMER_W = 20;
  typedef logic [TIMER_W-1:0] eac_timer_t;

  typedef enum logic {
    EAC_IDLE,
    EAC_BUSY
  } eac_prog_state_t;

  // true when a word address hits the given register index
  function automatic logic eac_hit(input logic [9:0] word_addr, input logic [7:0] idx);
    eac_hit = (word_addr == {2'h0, idx});
  endfunction

endpackage

// file: src/eac_eeprom_access_control.sv
/*
  eac_eeprom_access_control: register-level control of an on-chip data EEPROM, with
  its byte array kept in flip-flops, an APB slave and a sticky interrupt status.
  Assumes one clock (pclk); presetn is the system reset, por_n the supply-good reset
  that alone may stop a programming operation. cpu_irq_enable comes from the core
  on the same clock.
*/
`timescale 1ns/10ps

// How it works
// RULE_01: small variant keeps address bit 7 at zero; large variant uses it as address.
// RULE_02: bytes are addressed linearly from zero; seven low bits cover the small array.
// RULE_03: software loads an address before any access; its reset value means nothing.
// RULE_04: data register holds the byte to program, and after a read the fetched byte.
// RULE_05: control bits 7 and 6 ignore writes and read as zero.
// RULE_06: mode 00 atomic 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms, 11 reserved.
// RULE_07: while programming, writes to the mode field are discarded.
// RULE_08: reset returns mode to 00 unless a programming operation is still running.
// RULE_09: ready interrupt requested when enabled, global enable set and not programming.
// RULE_10: arm bit opens a four-cycle window, then hardware clears it.
// RULE_11: program strobe with arm bit clear starts nothing.
// RULE_12: valid program strobe starts the chosen mode and stalls the CPU two cycles.
// RULE_13: busy bit stays set for the whole programming time, then clears.
// RULE_14: while programming, software programming of flash, fuses and locks is blocked.
// RULE_15: read strobe fetches the addressed byte at once and stalls the CPU four cycles.
// RULE_16: while programming, read strobes are refused and the address cannot change.
// RULE_17: software should poll the busy bit clear before a read strobe.
// RULE_18: a running programming operation completes even through a system reset.
// RULE_19: ready interrupt is a level held while enabled and not programming.
module eac_eeprom_access_control #(
  parameter bit          LARGE_ARRAY   = 1'b1,
  parameter int unsigned ADDR_W        = 12,
  parameter int unsigned ATOMIC_CYCLES = eac_pkg::PROG_ATOMIC_CYCLES,
  parameter int unsigned SPLIT_CYCLES  = eac_pkg::PROG_SPLIT_CYCLES
) (
  input  wire logic              pclk,            // system clock, 250 MHz
  input  wire logic              presetn,         // system reset, async, active low
  input  wire logic              por_n,           // supply-good reset, async, active low
  input  wire logic              psel,            // apb select
  input  wire logic              penable,         // apb access phase
  input  wire logic              pwrite,          // apb direction, high for write
  input  wire logic [ADDR_W-1:0] paddr,           // apb byte address
  input  wire logic [31:0]       pwdata,          // apb write data
  output logic      [31:0]       prdata,          // apb read data
  output logic                   pready,          // apb ready
  output logic                   pslverr,         // apb error on unmapped address
  input  wire logic              cpu_irq_enable,  // global interrupt enable of the core
  output logic                   cpu_stall,       // core halt request
  output logic                   ready_irq,       // eeprom ready interrupt level
  output logic                   irq,             // masked sticky event interrupt
  output logic                   self_prog_block  // blocks flash, fuse and lock programming
);

  localparam int unsigned DEPTH = LARGE_ARRAY ? 256 : 128;

  // bus decode
  logic       setup_phase;
  logic       access_phase;
  logic       word_aligned;
  logic [9:0] word_addr;
  logic       sel_ctrl;
  logic       sel_data;
  logic       sel_addr;
  logic       sel_status;
  logic       sel_mask;
  logic       mapped;
  logic       bus_wr;
  logic       bus_rd;

  // system-reset state
  logic [7:0]  addr_q;
  logic [7:0]  data_q;
  logic        rie;
  logic        arm;
  logic [2:0]  arm_cnt;
  logic [2:0]  stall_cnt;
  logic [eac_pkg::EV_W-1:0] irq_status;
  logic [eac_pkg::EV_W-1:0] irq_mask;
  logic [31:0] prdata_q;
  logic [7:0]  next_addr_q;
  logic [7:0]  next_data_q;
  logic        next_rie;
  logic        next_arm;
  logic [2:0]  next_arm_cnt;
  logic [2:0]  next_stall_cnt;
  logic [eac_pkg::EV_W-1:0] next_irq_status;
  logic [eac_pkg::EV_W-1:0] next_irq_mask;
  logic [31:0] next_prdata_q;

  // supply-reset state: survives a system reset
  eac_pkg::eac_prog_state_t prog_state;
  eac_pkg::eac_prog_state_t next_prog_state;
  eac_pkg::eac_timer_t      timer;
  eac_pkg::eac_timer_t      next_timer;
  logic [1:0] mode;
  logic [1:0] next_mode;
  logic [1:0] prog_kind;
  logic [1:0] next_prog_kind;
  logic [7:0] prog_addr;
  logic [7:0] next_prog_addr;
  logic [7:0] prog_data;
  logic [7:0] next_prog_data;
  logic       rst_meta;
  logic       rst_seen;

  // byte array
  logic [7:0] mem [0:DEPTH-1];
  logic       mem_we;
  logic [7:0] mem_wdata;

  // control events
  logic       busy;
  logic       ctrl_wr;
  logic       prog_req;
  logic       prog_start;
  logic       read_req;
  logic       read_start;
  logic       addr_wr_refused;
  logic       prog_done;
  logic [1:0] wr_mode;
  logic [eac_pkg::EV_W-1:0] events;
  logic [eac_pkg::EV_W-1:0] status_clear;
  logic [7:0] ctrl_view;
  logic [7:0] addr_eff;

  // apb decode; slave answers in the first access cycle
  always_comb begin
    setup_phase  = psel & ~penable;
    access_phase = psel & penable;
    word_aligned = (paddr[1:0] == 2'h0);
    word_addr    = 10'(paddr[ADDR_W-1:2]);
    sel_ctrl     = word_aligned & eac_pkg::eac_hit(word_addr, eac_pkg::CTRL_IDX);
    sel_data     = word_aligned & eac_pkg::eac_hit(word_addr, eac_pkg::DATA_IDX);
    sel_addr     = word_aligned & eac_pkg::eac_hit(word_addr, eac_pkg::ADDR_IDX);
    sel_status   = word_aligned & eac_pkg::eac_hit(word_addr, eac_pkg::IRQ_STATUS_IDX);
    sel_mask     = word_aligned & eac_pkg::eac_hit(word_addr, eac_pkg::IRQ_MASK_IDX);
    mapped       = sel_ctrl | sel_data | sel_addr | sel_status | sel_mask;
    bus_wr       = access_phase & pwrite & mapped;
    bus_rd       = access_phase & ~pwrite & mapped;
  end

  assign pready  = 1'b1;
  assign pslverr = access_phase & ~mapped;
  assign prdata  = prdata_q;

  // strobes decoded from control and address writes, and the end of programming
  always_comb begin
    busy       = (prog_state == eac_pkg::EAC_BUSY);
    ctrl_wr    = bus_wr & sel_ctrl;
    wr_mode    = busy ? mode : pwdata[eac_pkg::CTRL_MODE_MSB:eac_pkg::CTRL_MODE_LSB];  // RULE_07
    prog_req   = ctrl_wr & pwdata[eac_pkg::CTRL_PROG_BIT];
    // the arm bit must already stand; setting it in the same write is too late
    prog_start = prog_req & arm & ~busy & (wr_mode != eac_pkg::MODE_RESERVED);  // RULE_11
    read_req   = ctrl_wr & pwdata[eac_pkg::CTRL_READ_BIT];
    read_start = read_req & ~busy & ~prog_start;  // RULE_16
    addr_wr_refused = bus_wr & sel_addr & busy;  // RULE_16
    prog_done  = busy & (timer == '0);
  end

  // small variant forces the top address bit low
  assign addr_eff = LARGE_ARRAY ? addr_q : {1'b0, addr_q[6:0]};  // RULE_01 RULE_02

  // control register image; reserved bits and read strobe read as zero
  always_comb begin
    ctrl_view = 8'h00;  // RULE_05
    ctrl_view[eac_pkg::CTRL_MODE_MSB:eac_pkg::CTRL_MODE_LSB] = mode;
    ctrl_view[eac_pkg::CTRL_RIE_BIT]  = rie;
    ctrl_view[eac_pkg::CTRL_ARM_BIT]  = arm;
    ctrl_view[eac_pkg::CTRL_PROG_BIT] = busy;
  end

  // sticky events
  always_comb begin
    events = '0;
    events[eac_pkg::EV_PROG_DONE] = prog_done;
    events[eac_pkg::EV_READ_DONE] = read_start;
    events[eac_pkg::EV_REFUSED]   = (prog_req & ~prog_start) | (read_req & ~read_start) | addr_wr_refused;
  end

  // next values of the bus-side registers
  always_comb begin
    next_addr_q     = addr_q;
    next_data_q     = data_q;
    next_rie        = rie;
    next_arm        = arm;
    next_arm_cnt    = arm_cnt;
    next_stall_cnt  = stall_cnt;
    next_irq_mask   = irq_mask;
    next_prdata_q   = prdata_q;
    status_clear    = '0;
    // address is frozen while programming
    if (bus_wr & sel_addr & ~busy) begin  // RULE_16
      next_addr_q = LARGE_ARRAY ? pwdata[7:0] : {1'b0, pwdata[6:0]};  // RULE_01
    end
    // data byte written by software, or fetched by a read strobe
    if (read_start) begin
      next_data_q = mem[addr_eff];  // RULE_15 RULE_04
    end else if (bus_wr & sel_data) begin
      next_data_q = pwdata[7:0];  // RULE_04
    end
    if (ctrl_wr) begin
      next_rie = pwdata[eac_pkg::CTRL_RIE_BIT];  // RULE_09
    end
    // arm window: counts down from four, rearming does not extend it
    if (arm) begin
      next_arm_cnt = arm_cnt - 3'h1;
      if (arm_cnt == 3'h1 || prog_start) begin
        next_arm     = 1'b0;  // RULE_10
        next_arm_cnt = 3'h0;
      end
    end else if (ctrl_wr & pwdata[eac_pkg::CTRL_ARM_BIT]) begin
      next_arm     = 1'b1;  // RULE_10
      next_arm_cnt = eac_pkg::ARM_WINDOW_CYCLES;
    end
    // core halt after a strobe
    if (prog_start) begin
      next_stall_cnt = eac_pkg::PROG_STALL_CYCLES;  // RULE_12
    end else if (read_start) begin
      next_stall_cnt = eac_pkg::READ_STALL_CYCLES;  // RULE_15
    end else if (stall_cnt != 3'h0) begin
      next_stall_cnt = stall_cnt - 3'h1;
    end
    if (bus_wr & sel_mask) begin
      next_irq_mask = pwdata[eac_pkg::EV_W-1:0];
    end
    // read data sampled in setup so the access cycle can answer at once
    if (setup_phase & ~pwrite) begin
      next_prdata_q = eac_pkg::RDATA_RESET;
      if (sel_ctrl) begin
        next_prdata_q[7:0] = ctrl_view;
      end else if (sel_data) begin
        next_prdata_q[7:0] = data_q;
      end else if (sel_addr) begin
        next_prdata_q[7:0] = addr_eff;
      end else if (sel_status) begin
        next_prdata_q[eac_pkg::EV_W-1:0] = irq_status;
      end else if (sel_mask) begin
        next_prdata_q[eac_pkg::EV_W-1:0] = irq_mask;
      end
    end
    // read clears only the bits that were reported; a new event wins
    if (bus_rd & sel_status) begin
      status_clear = prdata_q[eac_pkg::EV_W-1:0];
    end
    next_irq_status = (irq_status & ~status_clear) | events;
  end

  // bus-side registers, reset by the system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q     <= eac_pkg::ADDR_RESET;  // RULE_03
      data_q     <= eac_pkg::DATA_RESET;
      rie        <= 1'b0;
      arm        <= 1'b0;
      arm_cnt    <= 3'h0;
      stall_cnt  <= 3'h0;
      irq_status <= '0;
      irq_mask   <= '0;
      prdata_q   <= eac_pkg::RDATA_RESET;
    end else begin
      addr_q     <= next_addr_q;
      data_q     <= next_data_q;
      rie        <= next_rie;
      arm        <= next_arm;
      arm_cnt    <= next_arm_cnt;
      stall_cnt  <= next_stall_cnt;
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
      prdata_q   <= next_prdata_q;
    end
  end

  // system reset seen by the supply-reset domain, via two flops
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      rst_meta <= 1'b1;
      rst_seen <= 1'b1;
    end else begin
      rst_meta <= ~presetn;
      rst_seen <= rst_meta;
    end
  end

  // programming sequencer next values
  always_comb begin
    next_prog_state = prog_state;
    next_timer      = timer;
    next_mode       = mode;
    next_prog_kind  = prog_kind;
    next_prog_addr  = prog_addr;
    next_prog_data  = prog_data;
    // mode is writable only while idle
    if (ctrl_wr & ~busy) begin
      next_mode = pwdata[eac_pkg::CTRL_MODE_MSB:eac_pkg::CTRL_MODE_LSB];  // RULE_07
    end
    // a system reset clears the mode only when idle
    if (rst_seen & ~busy) begin
      next_mode = eac_pkg::MODE_RESET;  // RULE_08
    end
    case (prog_state)
      eac_pkg::EAC_IDLE: begin
        if (prog_start) begin
          next_prog_state = eac_pkg::EAC_BUSY;  // RULE_12
          next_prog_kind  = wr_mode;  // RULE_06
          next_prog_addr  = addr_eff;
          next_prog_data  = data_q;  // RULE_04
          if (wr_mode == eac_pkg::MODE_ATOMIC) begin
            next_timer = eac_pkg::eac_timer_t'(ATOMIC_CYCLES - 1);  // RULE_06
          end else begin
            next_timer = eac_pkg::eac_timer_t'(SPLIT_CYCLES - 1);  // RULE_06
          end
        end
      end
      eac_pkg::EAC_BUSY: begin
        // busy holds for the full count, then clears itself
        if (timer == '0) begin
          next_prog_state = eac_pkg::EAC_IDLE;  // RULE_13
        end else begin
          next_timer = timer - 1'b1;  // RULE_13
        end
      end
      default: begin
        next_prog_state = eac_pkg::EAC_IDLE;
      end
    endcase
  end

  // sequencer registers ignore presetn so an operation survives it
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      prog_state <= eac_pkg::EAC_IDLE;
      timer      <= '0;
      mode       <= eac_pkg::MODE_RESET;
      prog_kind  <= eac_pkg::MODE_ATOMIC;
      prog_addr  <= eac_pkg::ADDR_RESET;
      prog_data  <= eac_pkg::DATA_RESET;
    end else begin
      prog_state <= next_prog_state;  // RULE_18
      timer      <= next_timer;
      mode       <= next_mode;
      prog_kind  <= next_prog_kind;
      prog_addr  <= next_prog_addr;
      prog_data  <= next_prog_data;
    end
  end

  // array update at the end of the programming time
  always_comb begin
    mem_we    = prog_done;
    mem_wdata = prog_data;
    case (prog_kind)
      eac_pkg::MODE_ATOMIC:     mem_wdata = prog_data;
      eac_pkg::MODE_ERASE_ONLY: mem_wdata = eac_pkg::ERASED_BYTE;
      // write-only can only clear bits, so an unerased byte ends up corrupted
      eac_pkg::MODE_WRITE_ONLY: mem_wdata = mem[prog_addr] & prog_data;
      default:                  mem_wdata = mem[prog_addr];
    endcase
  end

  // non-volatile contents: no reset on purpose
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[prog_addr] <= mem_wdata;  // RULE_02
    end
  end

  // outputs
  assign cpu_stall       = (stall_cnt != 3'h0);  // RULE_12 RULE_15
  assign ready_irq       = rie & cpu_irq_enable & ~busy;  // RULE_09 RULE_19
  assign irq             = |(irq_status & irq_mask);
  assign self_prog_block = busy;  // RULE_14

endmodule

// file: testbench/eac_checker.sv
/*
  eac_checker: concurrent checks on the ports of the eeprom access control block.
  Assumes one clock, presetn as system reset and por_n as supply-good reset, bound by the bind below.
*/
`timescale 1ns/10ps
module eac_checker #(
  parameter int unsigned ADDR_W        = 12,
  parameter int unsigned ATOMIC_CYCLES = 40,
  parameter int unsigned SPLIT_CYCLES  = 20
) (
  input wire logic              pclk,            // clock
  input wire logic              presetn,         // system reset
  input wire logic              por_n,           // supply-good reset
  input wire logic              psel,            // apb select
  input wire logic              penable,         // apb access
  input wire logic              pwrite,          // apb direction
  input wire logic [ADDR_W-1:0] paddr,           // apb address
  input wire logic [31:0]       pwdata,          // apb write data
  input wire logic [31:0]       prdata,          // apb read data
  input wire logic              pready,          // apb ready
  input wire logic              pslverr,         // apb error
  input wire logic              cpu_irq_enable,  // global enable
  input wire logic              cpu_stall,       // core halt
  input wire logic              ready_irq,       // ready level
  input wire logic              irq,             // event interrupt
  input wire logic              self_prog_block  // busy programming
);
  localparam logic [ADDR_W-1:0] CTRL_A = ADDR_W'({eac_pkg::CTRL_IDX, 2'h0});
  logic [19:0] busy_cnt, next_busy_cnt;
  logic [1:0]  start_mode, next_start_mode;
  logic [2:0]  arm_age, next_arm_age;
  wire         wr_ctrl   = psel && penable && pwrite && paddr == CTRL_A;
  wire         rd_ctrl   = psel && penable && !pwrite && paddr == CTRL_A;
  wire         strobe_wr = wr_ctrl && pwdata[1];

  // busy length and mode survive presetn, so only por_n clears them
  always_comb begin
    next_busy_cnt   = self_prog_block ? busy_cnt + 20'h0_0001 : 20'h0_0000;
    next_start_mode = (strobe_wr && !self_prog_block) ? pwdata[5:4] : start_mode;
    next_arm_age    = (wr_ctrl && pwdata[2] && !pwdata[1]) ? 3'h0 : (arm_age == 3'h7 ? 3'h7 : arm_age + 3'h1);
  end
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      busy_cnt   <= 20'h0_0000;
      start_mode <= 2'h0;
    end else begin
      busy_cnt   <= next_busy_cnt;
      start_mode <= next_start_mode;
    end
  end
  // age since the last arm write; loose when arm is rewritten, stricter when arm comes with the program bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_age <= 3'h7;
    end else begin
      arm_age <= next_arm_age;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn || !por_n);

  sequence prog_stall_s;
    cpu_stall ##1 cpu_stall ##1 !cpu_stall;
  endsequence
  sequence read_stall_s;
    cpu_stall [*4] ##1 !cpu_stall;
  endsequence

  prog_stall_a: assert property ($rose(self_prog_block) |-> prog_stall_s)
    else $error("program start stall not two cycles");
  read_stall_a: assert property (wr_ctrl && pwdata[0] && !pwdata[1] && !self_prog_block |=> read_stall_s)
    else $error("read strobe stall not four cycles");
  read_refuse_a: assert property (wr_ctrl && pwdata[0] && self_prog_block && !cpu_stall |=> !cpu_stall)
    else $error("read strobe accepted while busy");
  ctrl_reserved_a: assert property (rd_ctrl |-> prdata[31:6] == 26'h000_0000)
    else $error("reserved control bits read nonzero");
  ready_level_a: assert property (ready_irq |-> cpu_irq_enable && !self_prog_block)
    else $error("ready interrupt while busy or disabled");
  busy_time_a: assert property (@(posedge pclk) disable iff (!por_n)
    $fell(self_prog_block) |-> busy_cnt == (start_mode == eac_pkg::MODE_ATOMIC ? 20'(ATOMIC_CYCLES) : 20'(SPLIT_CYCLES)))
    else $error("programming time wrong");
  strobe_start_a: assert property ($rose(self_prog_block) |-> $past(strobe_wr))
    else $error("programming started without strobe");
  arm_window_a: assert property ($rose(self_prog_block) |-> $past(arm_age) <= 3'h4)
    else $error("programming started outside arm window");
endmodule

bind eac_eeprom_access_control eac_checker #(.ADDR_W(ADDR_W), .ATOMIC_CYCLES(ATOMIC_CYCLES),
  .SPLIT_CYCLES(SPLIT_CYCLES)) chk_i (.pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cpu_irq_enable(cpu_irq_enable), .cpu_stall(cpu_stall), .ready_irq(ready_irq),
  .irq(irq), .self_prog_block(self_prog_block));

// file: testbench/eac_eeprom_access_control_test.sv
/*
  eac_eeprom_access_control_test: self-checking bench driving APB, global enable and both resets.
  Assumes short programming counts (40 and 20 cycles) and the checker bound to the design.
*/
`timescale 1ns/10ps
module eac_eeprom_access_control_test;
  localparam logic [11:0] CTRL_A = {2'h0, eac_pkg::CTRL_IDX, 2'h0};
  localparam logic [11:0] DATA_A = {2'h0, eac_pkg::DATA_IDX, 2'h0};
  localparam logic [11:0] ADDR_A = {2'h0, eac_pkg::ADDR_IDX, 2'h0};
  localparam logic [11:0] STAT_A = {2'h0, eac_pkg::IRQ_STATUS_IDX, 2'h0};
  localparam logic [11:0] MASK_A = {2'h0, eac_pkg::IRQ_MASK_IDX, 2'h0};
  logic        pclk = 1'b0;
  logic        presetn, por_n, psel, penable, pwrite, cpu_irq_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, cpu_stall, ready_irq, irq, self_prog_block;
  logic [32:0] exp_q[$];
  logic [7:0]  addr, data, stored;
  int          fail_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  int          busy_cycles = 0;
  int          n0;
  integer      seed = 10;

  always #2 pclk = ~pclk;

  eac_eeprom_access_control #(.LARGE_ARRAY(1'b1), .ADDR_W(12), .ATOMIC_CYCLES(40), .SPLIT_CYCLES(20)) uut (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_irq_enable(cpu_irq_enable), .cpu_stall(cpu_stall), .ready_irq(ready_irq), .irq(irq),
    .self_prog_block(self_prog_block));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_word(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [32:0] ok8(input logic [7:0] v);
    return {25'h000_0000, v};
  endfunction

  // psel stays high between transfers so no signal is assigned twice in one step
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(a, 1'b0, 32'h0000_0000);
  endtask

  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask

  // arm then strobe back to back, remembering the busy count at the start
  task automatic run_prog(input logic [1:0] m);
    wr(ADDR_A, {24'h00_0000, addr});
    wr(DATA_A, {24'h00_0000, data});
    wr(CTRL_A, {26'h000_0000, m, 4'hc});
    wr(CTRL_A, {26'h000_0000, m, 4'ha});
    n0 = busy_cycles;
  endtask

  task automatic wait_done;
    idle(1);
    while (self_prog_block !== 1'b0) @(posedge pclk);
  endtask

  // read results are compared where they appear, against the oldest note
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
      chk_word({pslverr, prdata}, exp_q.pop_front());
  end

  always @(posedge pclk) begin
    if (self_prog_block === 1'b1) busy_cycles++;
  end

  // whole run is about two hundred cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      stop_test();
    end
  end

  initial begin
    {presetn, por_n, psel, penable, pwrite, cpu_irq_enable} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    idle(3);
    rd(CTRL_A, ok8(8'h00));
    rd(MASK_A, ok8(8'h00));
    rd(12'h07c, 33'h1_0000_0000);
    wr(CTRL_A, 32'h0000_00c8);
    rd(CTRL_A, ok8(8'h08));
    cpu_irq_enable <= 1'b1;
    idle(2);
    chk_flag(ready_irq, 1'b1);
    cpu_irq_enable <= 1'b0;
    idle(2);
    chk_flag(ready_irq, 1'b0);
    cpu_irq_enable <= 1'b1;
    // top address bit forced high so the large array must keep it
    addr = 8'($random(seed)) | 8'h80;
    data = 8'($random(seed));
    for (int m = 0; m < 3; m++) begin
      run_prog(m[1:0]);
      rd(CTRL_A, ok8({2'h0, m[1:0], 4'ha}));
      wr(CTRL_A, 32'h0000_0039);
      rd(CTRL_A, ok8({2'h0, m[1:0], 4'ha}));
      wr(ADDR_A, {24'h00_0000, ~addr});
      rd(ADDR_A, ok8(addr));
      chk_flag(ready_irq, 1'b0);
      wait_done();
      chk_word(33'(busy_cycles - n0), (m == 0) ? 33'h0_0000_0028 : 33'h0_0000_0014);
      chk_flag(ready_irq, 1'b1);
      stored = (m == 0) ? data : ((m == 1) ? 8'hff : stored & data);
      wr(CTRL_A, 32'h0000_0009);
      rd(DATA_A, ok8(stored));
      data = 8'($random(seed));
    end
    wr(CTRL_A, 32'h0000_003c);
    wr(CTRL_A, 32'h0000_003a);
    idle(2);
    chk_flag(self_prog_block, 1'b0);
    wr(CTRL_A, 32'h0000_000a);
    idle(2);
    chk_flag(self_prog_block, 1'b0);
    wr(CTRL_A, 32'h0000_000c);
    rd(CTRL_A, ok8(8'h0c));
    idle(4);
    wr(CTRL_A, 32'h0000_000a);
    rd(CTRL_A, ok8(8'h08));
    chk_flag(self_prog_block, 1'b0);
    // events stay hidden until unmasked, a status read clears them
    chk_flag(irq, 1'b0);
    wr(MASK_A, 32'h0000_0007);
    idle(2);
    chk_flag(irq, 1'b1);
    rd(STAT_A, ok8(8'h07));
    idle(2);
    chk_flag(irq, 1'b0);
    rd(STAT_A, ok8(8'h00));
    run_prog(2'h1);
    idle(5);
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    idle(3);
    chk_flag(self_prog_block, 1'b1);
    rd(CTRL_A, ok8(8'h12));
    wait_done();
    chk_word(33'(busy_cycles - n0), 33'h0_0000_0014);
    rd(CTRL_A, ok8(8'h10));
    idle(1);
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    idle(3);
    rd(CTRL_A, ok8(8'h00));
    idle(2);
    stop_test();
  end
endmodule
